//--- inc/fesm_pkg.sv
// package for the flash erase, security and margin command sequencer
// assumes a single pclk domain; registers are reached over apb
package fesm_pkg;
    // register byte offsets
    localparam logic [11:0] off_status = 12'h000;
    localparam logic [11:0] off_index = 12'h004;
    localparam logic [11:0] off_param = 12'h008;
    localparam logic [11:0] off_security = 12'h00c;
    localparam logic [11:0] off_config = 12'h010;
    localparam logic [11:0] off_margin = 12'h014;
    localparam logic [11:0] off_key_base = 12'h020;
    // command opcodes
    localparam logic [7:0] op_sector_erase = 8'h0a;
    localparam logic [7:0] op_unsecure = 8'h0b;
    localparam logic [7:0] op_backdoor = 8'h0c;
    localparam logic [7:0] op_user_margin = 8'h0d;
    // launch indices
    localparam logic [2:0] idx_0 = 3'h0;
    localparam logic [2:0] idx_1 = 3'h1;
    localparam logic [2:0] idx_4 = 3'h4;
    localparam int num_params = 6;
    localparam int num_blocks = 4;
    localparam int num_keys = 4;
    // margin levels
    localparam logic [15:0] margin_normal = 16'h0000;
    localparam logic [15:0] margin_user1 = 16'h0001;
    localparam logic [15:0] margin_user0 = 16'h0002;
    // field codes
    localparam logic [1:0] key_enabled = 2'h2;
    localparam logic [2:0] align_ok = 3'h0;
    localparam logic [6:0] block_base = 7'h7c;
    // status bit positions
    localparam int bit_complete = 7;
    localparam int bit_access = 5;
    localparam int bit_protect = 4;
    localparam int bit_verify1 = 1;
    localparam int bit_verify0 = 0;
    // timing of the array engine
    localparam int erase_time_us = 20;
    localparam int clk_mhz = 200;
    localparam int erase_cycles = erase_time_us * clk_mhz;
    typedef enum logic [2:0] {
        fesm_idle = 3'b000,
        fesm_erase = 3'b001,
        fesm_verify = 3'b010,
        fesm_compare = 3'b011,
        fesm_done = 3'b100
    } fesm_state_type;
endpackage

//--- logic/fesm_sync.sv
// two flop synchroniser for one level
// assumes the input is asynchronous to pclk
`timescale 1ns/1ps
module fesm_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic first;
        logic second;
    } fesm_sync_type;
    fesm_sync_type r;
    fesm_sync_type next_r;
    // first stage only feeds the second
    always_comb begin
        next_r.first = din;
        next_r.second = r.first;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign dout = r.second;
endmodule

//--- logic/fesm_timer.sv
// down counter that marks the end of an array operation
// assumes start is a one cycle pulse from the sequencer
`timescale 1ns/1ps
module fesm_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [15:0] length,
    output logic expired
);
    typedef struct packed {
        logic [15:0] count;
        logic running;
        logic expired;
    } fesm_timer_type;
    fesm_timer_type r;
    fesm_timer_type next_r;
    // expired pulses one cycle after the count runs out
    always_comb begin
        next_r = r;
        next_r.expired = 1'b0;
        if (start) begin
            next_r.count = length;
            next_r.running = 1'b1;
        end else if (r.running) begin
            if (r.count <= 16'h0001) begin
                next_r.running = 1'b0;
                next_r.expired = 1'b1;
            end else begin
                next_r.count = r.count - 16'h0001;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign expired = r.expired;
endmodule

//--- logic/fesm_top.sv
// command sequencer for sector erase, unsecure, backdoor key and user margin
// assumes an apb master on pclk, and an array that reports verify results on pins
// assumes verify pins settle before the erase timer runs out
// assumes software writes nothing while the complete flag is low
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module fesm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic verify_fail,
    input wire logic verify_uncorrectable,
    input wire logic special_mode,
    output logic secured,
    output logic [1:0] block_margin [fesm_pkg::num_blocks],
    output logic erase_active
);

    // all sequencer state except the stored key in one struct
    typedef struct packed {
        // machine and loaded words
        fesm_pkg::fesm_state_type state;
        logic [2:0] command_param_index;
        logic [15:0] param0;
        logic [15:0] param1;
        logic [15:0] param2;
        logic [15:0] param3;
        logic [15:0] param4;
        // status flags
        logic command_complete_flag;
        logic access_error_flag;
        logic protection_violation_flag;
        logic verify_error_flag;
        logic verify_uncorrectable_flag;
        // security and configuration
        logic secured;
        logic key_lockout;
        logic [7:0] security_config_register;
        logic [7:0] protect_mask;
        logic [7:0] mode_mask;
        // read margin per block
        logic [1:0] margin0;
        logic [1:0] margin1;
        logic [1:0] margin2;
        logic [1:0] margin3;
        // command in flight, bus answer
        logic [7:0] opcode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic erase_active;
        logic timer_start;
    } fesm_top_type;

    fesm_top_type r;
    fesm_top_type next_r;

    // comparison key kept beside the struct
    logic [15:0] stored_key [fesm_pkg::num_keys];
    logic [15:0] next_key [fesm_pkg::num_keys];

    // timer end and synchronised pins
    logic timer_done;
    logic fail_sync;
    logic unc_sync;
    logic mode_sync;

    // launch decode and bus strobes
    logic [1:0] key_en;
    logic block_bad;
    logic [1:0] blk;
    logic wr_strobe;
    logic rd_strobe;
    logic cmd_ok;
    ////////////////////////////////////////////////////////////////////////
    // pins from the array are asynchronous to pclk
    fesm_sync u_sync_fail (.pclk(pclk), .presetn(presetn), .din(verify_fail), .dout(fail_sync));
    fesm_sync u_sync_unc (.pclk(pclk), .presetn(presetn), .din(verify_uncorrectable), .dout(unc_sync));
    fesm_sync u_sync_mode (.pclk(pclk), .presetn(presetn), .din(special_mode), .dout(mode_sync));

    // one timer serves both erase commands
    fesm_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(r.timer_start),
        .length(16'(fesm_pkg::erase_cycles)),
        .expired(timer_done)
    );
    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    assign key_en = r.security_config_register[7:6];
    assign blk = r.param0[1:0];
    assign block_bad = r.param0[6:2] != fesm_pkg::block_base[6:2];
    assign wr_strobe = psel && penable && pwrite && !r.pready;
    assign rd_strobe = psel && penable && !pwrite && !r.pready;

    // mode mask bit per opcode low three bits; set means allowed in normal mode
    always_comb begin
        cmd_ok = mode_sync || r.mode_mask[r.param0[10:8]];
    end
    ////////////////////////////////////////////////////////////////////////
    // sequencer and registers
    always_comb begin
        next_r = r;
        next_key = stored_key;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.timer_start = 1'b0;

        // apb slave: one wait state, answer in the access phase
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
        end

        // reads have no side effects
        if (rd_strobe) begin
            unique case (paddr)
                fesm_pkg::off_status: next_r.prdata = {24'h000000, r.command_complete_flag, 1'b0,
                    r.access_error_flag, r.protection_violation_flag, 2'h0,
                    r.verify_error_flag, r.verify_uncorrectable_flag};
                fesm_pkg::off_index: next_r.prdata = {29'h00000000, r.command_param_index};
                fesm_pkg::off_security: next_r.prdata = {23'h000000, r.secured, r.security_config_register};
                fesm_pkg::off_config: next_r.prdata = {16'h0000, r.mode_mask, r.protect_mask};
                fesm_pkg::off_margin: next_r.prdata = {24'h000000, r.margin3, r.margin2, r.margin1, r.margin0};
                default: begin
                    next_r.prdata = 32'h00000000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end

        // writes are ignored while a command runs so parameters stay stable
        if (wr_strobe && r.command_complete_flag) begin
            unique case (paddr)
                fesm_pkg::off_index: next_r.command_param_index = pwdata[2:0];
                fesm_pkg::off_param: begin
                    unique case (r.command_param_index)
                        3'h0: next_r.param0 = pwdata[15:0];
                        3'h1: next_r.param1 = pwdata[15:0];
                        3'h2: next_r.param2 = pwdata[15:0];
                        3'h3: next_r.param3 = pwdata[15:0];
                        3'h4: next_r.param4 = pwdata[15:0];
                        default: next_r.pslverr = 1'b1;
                    endcase
                end
                fesm_pkg::off_security: next_r.security_config_register = pwdata[7:0];
                fesm_pkg::off_config: begin
                    next_r.protect_mask = pwdata[7:0];
                    next_r.mode_mask = pwdata[15:8];
                end
                // keys load but never read back
                fesm_pkg::off_key_base: next_key[0] = pwdata[15:0];
                fesm_pkg::off_key_base + 12'h004: next_key[1] = pwdata[15:0];
                fesm_pkg::off_key_base + 12'h008: next_key[2] = pwdata[15:0];
                fesm_pkg::off_key_base + 12'h00c: next_key[3] = pwdata[15:0];
                fesm_pkg::off_status: begin
                    // access and protection error flags clear by writing one
                    if (pwdata[fesm_pkg::bit_access]) next_r.access_error_flag = 1'b0;
                    if (pwdata[fesm_pkg::bit_protect]) next_r.protection_violation_flag = 1'b0;

                    // writing one to the complete flag launches a command
                    if (pwdata[fesm_pkg::bit_complete]) begin
                        next_r.command_complete_flag = 1'b0;
                        next_r.verify_error_flag = 1'b0;
                        next_r.verify_uncorrectable_flag = 1'b0;
                        // judged on words loaded before launch
                        next_r.opcode = r.param0[15:8];
                        next_r.state = fesm_pkg::fesm_done;
                        if (!cmd_ok) begin
                            next_r.access_error_flag = 1'b1;
                        end else begin
                            unique case (r.param0[15:8])
                                // index, block, alignment, protection
                                fesm_pkg::op_sector_erase: begin
                                    if (r.command_param_index != fesm_pkg::idx_1 || block_bad) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else if (r.param1[2:0] != fesm_pkg::align_ok) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else if (r.protect_mask[r.param1[15:13]]) begin
                                        next_r.protection_violation_flag = 1'b1;
                                    end else begin
                                        next_r.state = fesm_pkg::fesm_erase;
                                        next_r.timer_start = 1'b1;
                                    end
                                end

                                // any protected region refuses it
                                fesm_pkg::op_unsecure: begin
                                    if (r.command_param_index != fesm_pkg::idx_0) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else if (r.protect_mask != 8'h00) begin
                                        next_r.protection_violation_flag = 1'b1;
                                    end else begin
                                        next_r.state = fesm_pkg::fesm_erase;
                                        next_r.timer_start = 1'b1;
                                    end
                                end

                                // lockout and enable before compare
                                fesm_pkg::op_backdoor: begin
                                    if (r.command_param_index != fesm_pkg::idx_4 || r.key_lockout) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else if (key_en != fesm_pkg::key_enabled) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else begin
                                        next_r.state = fesm_pkg::fesm_compare;
                                    end
                                end

                                // no array work, takes effect at once
                                fesm_pkg::op_user_margin: begin
                                    if (r.command_param_index != fesm_pkg::idx_1 || block_bad) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else if (r.param1 != fesm_pkg::margin_normal &&
                                                 r.param1 != fesm_pkg::margin_user1 &&
                                                 r.param1 != fesm_pkg::margin_user0) begin
                                        next_r.access_error_flag = 1'b1;
                                    end else begin
                                        // margin-1 code drives erased-side read bias on the array
                                        unique case (blk)
                                            2'h0: next_r.margin0 = r.param1[1:0];
                                            2'h1: next_r.margin1 = r.param1[1:0];
                                            2'h2: next_r.margin2 = r.param1[1:0];
                                            2'h3: next_r.margin3 = r.param1[1:0];
                                        endcase
                                    end
                                end
                                default: next_r.access_error_flag = 1'b1;
                            endcase
                        end
                    end
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end

        // command execution; a rejected launch goes straight to done
        unique case (r.state)
            fesm_pkg::fesm_idle: begin
                // waits for a launch
            end

            // erase_active spans the array phase
            fesm_pkg::fesm_erase: begin
                next_r.erase_active = 1'b1;
                if (timer_done) begin
                    next_r.erase_active = 1'b0;
                    next_r.state = fesm_pkg::fesm_verify;
                end
            end

            // pins are read once as erase ends
            fesm_pkg::fesm_verify: begin
                // set wins over clear: flags are cleared only at launch
                if (fail_sync || unc_sync) begin
                    next_r.verify_error_flag = 1'b1;
                end
                if (unc_sync) begin
                    next_r.verify_uncorrectable_flag = 1'b1;
                end
                if (r.opcode == fesm_pkg::op_unsecure && !fail_sync && !unc_sync) begin
                    next_r.secured = 1'b0;
                end
                next_r.state = fesm_pkg::fesm_done;
            end

            // one wrong word locks the command out
            fesm_pkg::fesm_compare: begin
                if (r.param1 == stored_key[0] && r.param2 == stored_key[1] &&
                    r.param3 == stored_key[2] && r.param4 == stored_key[3]) begin
                    next_r.secured = 1'b0;
                end else begin
                    next_r.access_error_flag = 1'b1;
                    next_r.key_lockout = 1'b1;
                end
                next_r.state = fesm_pkg::fesm_done;
            end

            // every command ends here
            fesm_pkg::fesm_done: begin
                next_r.command_complete_flag = 1'b1;
                next_r.state = fesm_pkg::fesm_idle;
            end
            default: next_r.state = fesm_pkg::fesm_idle;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // state registers; lockout clears only by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.command_complete_flag <= 1'b1;
            r.secured <= 1'b1;
            r.mode_mask <= 8'hff;
            for (int i = 0; i < fesm_pkg::num_keys; i++) begin
                stored_key[i] <= 16'h0000;
            end
        end else begin
            r <= next_r;
            stored_key <= next_key;
        end
    end

    // outputs straight from state flops
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign secured = r.secured;
    assign erase_active = r.erase_active;
    assign block_margin[0] = r.margin0;
    assign block_margin[1] = r.margin1;
    assign block_margin[2] = r.margin2;
    assign block_margin[3] = r.margin3;
endmodule

//--- bench/fesm_monitor.sv
// port checker for the flash command sequencer
// assumes it is bound to fesm_top and sees only its ports
`timescale 1ns/1ps
module fesm_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic verify_fail,
    input wire logic verify_uncorrectable,
    input wire logic special_mode,
    input wire logic secured,
    input wire logic [1:0] block_margin [fesm_pkg::num_blocks],
    input wire logic erase_active
);
    logic [12:0] on_cnt;
    logic [7:0] bm_all;
    ////////////////////////////////////////////////////////////////////////////////
    // erase phase length; erase_active falls a cycle after the timer expires, so it stands one extra cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_cnt <= 13'h0;
        end else begin
            on_cnt <= erase_active ? on_cnt + 13'h1 : 13'h0;
        end
    end
    assign bm_all = {block_margin[3], block_margin[2], block_margin[1], block_margin[0]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_timing: assert property ($rose(penable) && psel |=> pready) else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held two cycles");
    a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside an access");
    a_unmapped_err: assert property (pready && paddr == 12'h018 |-> pslverr) else $error("unmapped address accepted");
    a_erase_span: assert property ($fell(erase_active) |-> on_cnt == 13'(fesm_pkg::erase_cycles + 1))
        else $error("erase phase length wrong");
    a_secure_sticky: assert property (!$rose(secured))
        else $error("security engaged outside reset");
    a_secure_erase: assert property (erase_active && $past(erase_active) |-> $stable(secured))
        else $error("security changed before verify");
    a_margin_legal: assert property (bm_all[1:0] != 2'h3 && bm_all[3:2] != 2'h3 && bm_all[5:4] != 2'h3
        && bm_all[7:6] != 2'h3) else $error("illegal margin level");
    a_margin_erase: assert property (erase_active |-> $stable(bm_all))
        else $error("margin changed during erase");
    c_erase_end: cover property ($fell(erase_active));
    c_release: cover property ($fell(secured));
    c_margin: cover property ($changed(bm_all));
endmodule
bind fesm_top fesm_monitor u_fesm_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .verify_fail(verify_fail), .verify_uncorrectable(verify_uncorrectable), .special_mode(special_mode),
    .secured(secured), .block_margin(block_margin), .erase_active(erase_active));

//--- bench/tb.sv
// self-checking bench for the flash command sequencer
// assumes fesm_top with its apb slave; reads are queued and checked by a watcher
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
    logic verify_fail = 1'b0, verify_uncorrectable = 1'b0, special_mode = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, secured, erase_active;
    logic [1:0] block_margin [fesm_pkg::num_blocks];
    logic [32:0] exp_q[$], msk_q[$];
    logic [15:0] p [5], key [4], a;
    logic [7:0] mg = 8'h0;
    logic [1:0] b;
    int miscompares = 0, samples_checked = 0;
    always #2.5 pclk = ~pclk;
    fesm_top u_fesm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .verify_fail(verify_fail), .verify_uncorrectable(verify_uncorrectable), .special_mode(special_mode),
        .secured(secured), .block_margin(block_margin), .erase_active(erase_active));
    ////////////////////////////////////////////////////////////////////////////////
    task compare(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // watcher takes the oldest note when a flagged read completes
    always @(posedge pclk) begin
        if (psel && penable && pready && want) begin
            compare({pslverr, prdata} & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // request held until pready is sampled high; the wait is bounded
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic c);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        want <= c;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) miscompares++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        want <= 1'b0;
        @(posedge pclk);
    endtask
    task chk(input logic [11:0] ad, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        apb(1'b0, ad, 32'h0, 1'b1);
    endtask
    // clears sticky flags, loads all five words, launches, polls completion, checks status
    task cmd(input logic [2:0] ix, input logic [7:0] st);
        int n;
        apb(1'b1, fesm_pkg::off_status, 32'h30, 1'b0);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, fesm_pkg::off_index, 32'(i), 1'b0);
            apb(1'b1, fesm_pkg::off_param, {16'h0, p[i]}, 1'b0);
        end
        apb(1'b1, fesm_pkg::off_index, {29'h0, ix}, 1'b0);
        apb(1'b1, fesm_pkg::off_status, 32'h80, 1'b0);
        n = 0;
        do begin
            apb(1'b0, fesm_pkg::off_status, 32'h0, 1'b0);
            n++;
        end while (rd[7] !== 1'b1 && n < 3000);
        chk(fesm_pkg::off_status, {25'h0, st}, 33'h1_0000_00b3);
    endtask
    // reset mid-run, then reload keys with the backdoor enabled
    task rst_keys;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, fesm_pkg::off_key_base + 12'(4 * k), {16'h0, key[k]}, 1'b0);
        end
        apb(1'b1, fesm_pkg::off_security, 32'h80, 1'b0);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        final_report;
    end
    initial begin
        void'($urandom(32'h69c9c7fc));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, fesm_pkg::off_config, 32'hff00, 1'b0);
        chk(12'h018, 33'h1_0000_0000, 33'h1_0000_0000);
        for (int l = 0; l < 4; l++) begin
            b = 2'($urandom_range(3));
            p = '{{8'h0d, 1'b0, 5'h1f, b}, 16'(l), 16'h0, 16'h0, 16'h0};
            cmd(3'h1, l == 3 ? 8'ha0 : 8'h80);
            if (l < 3) mg[2 * b +: 2] = 2'(l);
            chk(fesm_pkg::off_margin, {25'h0, mg}, 33'h1_0000_00ff);
            compare({25'h0, block_margin[3], block_margin[2], block_margin[1], block_margin[0]}, {25'h0, mg});
        end
        $display("margin test done");
        a = 16'($urandom) & 16'hfff8;
        p = '{16'h0a7c, a, 16'h0, 16'h0, 16'h0};
        cmd(3'h0, 8'ha0);
        p[1] = a | 16'h4;
        cmd(3'h1, 8'ha0);
        p = '{16'h0a7b, a, 16'h0, 16'h0, 16'h0};
        cmd(3'h1, 8'ha0);
        p[0] = 16'h0a7d;
        apb(1'b1, fesm_pkg::off_config, 32'hff00 | (32'h1 << a[15:13]), 1'b0);
        cmd(3'h1, 8'h90);
        apb(1'b1, fesm_pkg::off_config, 32'hff00, 1'b0);
        verify_fail <= 1'b1;
        cmd(3'h1, 8'h82);
        verify_uncorrectable <= 1'b1;
        cmd(3'h1, 8'h83);
        verify_fail <= 1'b0;
        verify_uncorrectable <= 1'b0;
        cmd(3'h1, 8'h80);
        $display("erase test done");
        special_mode <= 1'b0;
        apb(1'b1, fesm_pkg::off_config, 32'h0, 1'b0);
        p = '{16'h0d7c, 16'h0, 16'h0, 16'h0, 16'h0};
        cmd(3'h1, 8'ha0);
        apb(1'b1, fesm_pkg::off_config, 32'hff00, 1'b0);
        cmd(3'h1, 8'h80);
        special_mode <= 1'b1;
        $display("mode test done");
        p[0] = 16'h0b00;
        cmd(3'h1, 8'ha0);
        apb(1'b1, fesm_pkg::off_config, 32'hff01, 1'b0);
        cmd(3'h0, 8'h90);
        apb(1'b1, fesm_pkg::off_config, 32'hff00, 1'b0);
        verify_fail <= 1'b1;
        cmd(3'h0, 8'h82);
        chk(fesm_pkg::off_security, 33'h100, 33'h1_0000_0100);
        verify_fail <= 1'b0;
        cmd(3'h0, 8'h80);
        chk(fesm_pkg::off_security, 33'h0, 33'h1_0000_0100);
        $display("unsecure test done");
        for (int k = 0; k < 4; k++) key[k] = 16'($urandom);
        rst_keys;
        chk(fesm_pkg::off_key_base, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b1, fesm_pkg::off_security, 32'h0, 1'b0);
        p = '{16'h0c00, key[0], key[1], key[2], key[3]};
        cmd(3'h4, 8'ha0);
        apb(1'b1, fesm_pkg::off_security, 32'h80, 1'b0);
        cmd(3'h3, 8'ha0);
        p[2] = ~key[1];
        cmd(3'h4, 8'ha0);
        chk(fesm_pkg::off_security, 33'h100, 33'h1_0000_0100);
        p[2] = key[1];
        cmd(3'h4, 8'ha0);
        rst_keys;
        cmd(3'h4, 8'h80);
        chk(fesm_pkg::off_security, 33'h0, 33'h1_0000_0100);
        $display("backdoor test done");
        final_report;
    end
endmodule
